//--- common/sfb_pkg.sv
package sfb_pkg;
  localparam int CLK_PERIOD_NS = 8;
  localparam int T_RST_US = 300;
  localparam int RST_CYC = (T_RST_US * 1000) / CLK_PERIOD_NS;
  localparam int RCNT_W = 16;
  localparam logic [7:0] OP_RST_EN = 8'h66;
  localparam logic [7:0] OP_RST = 8'h99;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST = 8'h0b;
  localparam logic [7:0] OP_DOUT = 8'h3b;
  localparam logic [7:0] OP_DIO = 8'hbb;
  localparam logic [7:0] OP_QOUT = 8'h6b;
  localparam logic [7:0] OP_QIO = 8'heb;
  localparam logic [7:0] OP_PROG = 8'h02;
  localparam logic [7:0] OP_SEC_ER = 8'h20;
  localparam logic [7:0] OP_HBLK_ER = 8'h52;
  localparam logic [7:0] OP_BLK_ER = 8'hd8;
  localparam int ADDR_W = 18;
  localparam int SEC_LSB = 12;
  localparam int HBLK_LSB = 15;
  localparam int BLK_LSB = 16;
  localparam int OP_LAST = 7;
  localparam logic [4:0] A_CLK1 = 5'h18;
  localparam logic [4:0] A_CLK2 = 5'h0c;
  localparam logic [4:0] A_CLK4 = 5'h06;
  localparam logic [4:0] M_CLK2 = 5'h04;
  localparam logic [4:0] M_CLK4 = 5'h02;
  localparam logic [4:0] D_FAST = 5'h08;
  localparam logic [4:0] D_QIO = 5'h04;
  localparam logic [3:0] OE_OFF = 4'hf;

  typedef enum logic [2:0] {PH_OP, PH_ADDR, PH_MODE, PH_DUMMY, PH_DOUT, PH_IDLE} sfb_phase_t;

  typedef struct packed {
    logic [2:0] ain;
    logic [4:0] aclk;
    logic [4:0] mclk;
    logic [4:0] dclk;
    logic dout;
    logic [2:0] wout;
    logic quad;
  } sfb_plan_t;

  typedef struct packed {
    logic acc_s1;
    logic acc_s2;
    logic qe_s1;
    logic qe_s2;
    logic hs_s1;
    logic hs_s2;
    logic [7:0] rd_s1;
    logic [7:0] rd_s2;
    sfb_phase_t ph;
    logic [4:0] cnt;
    sfb_plan_t pl;
    logic [7:0] op;
    logic op_done;
    logic [23:0] addr;
    logic addr_done;
  } sfb_rise_t;

  typedef struct packed {
    logic [7:0] sh;
    logic [2:0] left;
    logic [3:0] dq;
    logic [3:0] oe_n;
  } sfb_fall_t;

  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic sck_s1;
    logic sck_s2;
    logic pn_s1;
    logic pn_s2;
    logic por_s1;
    logic por_s2;
    logic od_s1;
    logic od_s2;
    logic od_prev;
    logic ad_s1;
    logic ad_s2;
    logic ad_prev;
    logic qe;
    logic hs;
    logic armed;
    logic acc;
    logic rst_en;
    logic rst_busy;
    logic [RCNT_W-1:0] rcnt;
    logic hw_low;
    logic paused;
    logic selected;
    logic standby;
    logic [7:0] opcode;
    logic op_valid;
    logic [ADDR_W-1:0] addr;
    logic addr_valid;
    logic [5:0] sector;
    logic [2:0] half_block;
    logic [1:0] block;
    logic sw_reset;
  } sfb_core_t;
endpackage

//--- hdl/sfb_front_end.sv
`timescale 1ns/1ps
module sfb_front_end #(
  parameter int RST_CYCLES = sfb_pkg::RST_CYC
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic [3:0] dl_i,
  input wire logic por_i,
  input wire logic quad_enable_bit_i,
  input wire logic pause_or_reset_select_i,
  input wire logic write_busy_i,
  input wire logic [7:0] rd_data_i,
  output logic [3:0] dl_o,
  output logic [3:0] dl_oe_n_o,
  output logic [7:0] opcode_o,
  output logic op_valid_o,
  output logic [17:0] addr_o,
  output logic addr_valid_o,
  output logic [5:0] sector_o,
  output logic [2:0] half_block_o,
  output logic [1:0] block_o,
  output logic selected_o,
  output logic standby_o,
  output logic paused_o,
  output logic reset_busy_o,
  output logic sw_reset_o
);

  localparam sfb_pkg::sfb_fall_t FALL_RST = '{sh: 8'h00, left: 3'h0, dq: 4'h0, oe_n: sfb_pkg::OE_OFF};

  sfb_pkg::sfb_rise_t rs, rs_d;
  sfb_pkg::sfb_fall_t fs, fs_d;
  sfb_pkg::sfb_core_t q, q_d;

  function automatic sfb_pkg::sfb_plan_t plan(input logic [7:0] op);
    plan = '0;
    plan.ain = 3'h1;
    plan.wout = 3'h1;
    case (op)
      sfb_pkg::OP_READ, sfb_pkg::OP_PROG, sfb_pkg::OP_SEC_ER, sfb_pkg::OP_HBLK_ER, sfb_pkg::OP_BLK_ER: begin
        plan.aclk = sfb_pkg::A_CLK1;
        plan.dout = (op == sfb_pkg::OP_READ);
      end
      sfb_pkg::OP_FAST: begin
        plan.aclk = sfb_pkg::A_CLK1;
        plan.dclk = sfb_pkg::D_FAST;
        plan.dout = 1'b1;
      end
      sfb_pkg::OP_DOUT: begin
        plan.aclk = sfb_pkg::A_CLK1;
        plan.dclk = sfb_pkg::D_FAST;
        plan.dout = 1'b1;
        plan.wout = 3'h2;
      end
      sfb_pkg::OP_DIO: begin
        plan.ain = 3'h2;
        plan.aclk = sfb_pkg::A_CLK2;
        plan.mclk = sfb_pkg::M_CLK2;
        plan.dout = 1'b1;
        plan.wout = 3'h2;
      end
      sfb_pkg::OP_QOUT: begin
        plan.aclk = sfb_pkg::A_CLK1;
        plan.dclk = sfb_pkg::D_FAST;
        plan.dout = 1'b1;
        plan.wout = 3'h4;
        plan.quad = 1'b1;
      end
      sfb_pkg::OP_QIO: begin
        plan.ain = 3'h4;
        plan.aclk = sfb_pkg::A_CLK4;
        plan.mclk = sfb_pkg::M_CLK4;
        plan.dclk = sfb_pkg::D_QIO;
        plan.dout = 1'b1;
        plan.wout = 3'h4;
        plan.quad = 1'b1;
      end
      default: plan.aclk = 5'h00;
    endcase
  endfunction

  function automatic sfb_pkg::sfb_phase_t follow(input sfb_pkg::sfb_plan_t p, input sfb_pkg::sfb_phase_t ph);
    follow = sfb_pkg::PH_IDLE;
    if (ph == sfb_pkg::PH_ADDR && p.mclk != 5'h00) begin
      follow = sfb_pkg::PH_MODE;
    end else if (ph != sfb_pkg::PH_DUMMY && p.dclk != 5'h00) begin
      follow = sfb_pkg::PH_DUMMY;
    end else if (p.dout) begin
      follow = sfb_pkg::PH_DOUT;
    end
  endfunction

  // Link side, rising edge: the frame is ended by select itself
  logic r_paused;
  logic [4:0] cnt_nx;
  sfb_pkg::sfb_plan_t nplan;

  always_comb begin
    rs_d = rs;
    rs_d.acc_s1 = q.acc;
    rs_d.acc_s2 = rs.acc_s1;
    rs_d.qe_s1 = q.qe;
    rs_d.qe_s2 = rs.qe_s1;
    rs_d.hs_s1 = q.hs;
    rs_d.hs_s2 = rs.hs_s1;
    rs_d.rd_s1 = rd_data_i;
    rs_d.rd_s2 = rs.rd_s1;
    r_paused = !rs.qe_s2 && !rs.hs_s2 && !dl_i[3];
    cnt_nx = rs.cnt + 5'h01;
    nplan = plan({rs.op[6:0], dl_i[0]});
    if (!r_paused) begin
      case (rs.ph)
        sfb_pkg::PH_OP: begin
          rs_d.op = {rs.op[6:0], dl_i[0]};
          rs_d.cnt = cnt_nx;
          if (rs.cnt == 5'(sfb_pkg::OP_LAST)) begin
            rs_d.cnt = 5'h00;
            rs_d.pl = nplan;
            rs_d.ph = sfb_pkg::PH_IDLE;
            if (rs.acc_s2 && !(nplan.quad && !rs.qe_s2)) begin
              rs_d.op_done = 1'b1;
              if (nplan.aclk != 5'h00) begin
                rs_d.ph = sfb_pkg::PH_ADDR;
              end
            end
          end
        end
        sfb_pkg::PH_ADDR: begin
          case (rs.pl.ain)
            3'h4: rs_d.addr = {rs.addr[19:0], dl_i[3:0]};
            3'h2: rs_d.addr = {rs.addr[21:0], dl_i[1:0]};
            default: rs_d.addr = {rs.addr[22:0], dl_i[0]};
          endcase
          rs_d.cnt = cnt_nx;
          if (cnt_nx == rs.pl.aclk) begin
            rs_d.cnt = 5'h00;
            rs_d.addr_done = 1'b1;
            rs_d.ph = follow(rs.pl, rs.ph);
          end
        end
        sfb_pkg::PH_MODE, sfb_pkg::PH_DUMMY: begin
          rs_d.cnt = cnt_nx;
          if (cnt_nx == ((rs.ph == sfb_pkg::PH_MODE) ? rs.pl.mclk : rs.pl.dclk)) begin
            rs_d.cnt = 5'h00;
            rs_d.ph = follow(rs.pl, rs.ph);
          end
        end
        sfb_pkg::PH_DOUT, sfb_pkg::PH_IDLE: rs_d.cnt = rs.cnt;
        default: rs_d.ph = sfb_pkg::PH_IDLE;
      endcase
    end
  end

  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) rs <= '0;
    else rs <= rs_d;
  end

  // Link side, falling edge: output lanes
  logic f_paused;
  logic [7:0] f_byte;
  logic [2:0] f_per;

  always_comb begin
    fs_d = fs;
    f_paused = !rs.qe_s2 && !rs.hs_s2 && !dl_i[3];
    f_byte = (fs.left == 3'h0) ? rs.rd_s2 : fs.sh;
    f_per = 3'h7;
    if (rs.ph != sfb_pkg::PH_DOUT || f_paused) begin
      fs_d.oe_n = sfb_pkg::OE_OFF;
    end else begin
      case (rs.pl.wout)
        3'h4: begin
          fs_d.dq = f_byte[7:4];
          fs_d.oe_n = 4'h0;
          fs_d.sh = {f_byte[3:0], 4'h0};
          f_per = 3'h1;
        end
        3'h2: begin
          fs_d.dq = {2'h0, f_byte[7:6]};
          fs_d.oe_n = 4'hc;
          fs_d.sh = {f_byte[5:0], 2'h0};
          f_per = 3'h3;
        end
        default: begin
          fs_d.dq = {2'h0, f_byte[7], 1'b0};
          fs_d.oe_n = 4'hd;
          fs_d.sh = {f_byte[6:0], 1'b0};
        end
      endcase
      fs_d.left = (fs.left == 3'h0) ? f_per : fs.left - 3'h1;
    end
  end

  always_ff @(negedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) fs <= FALL_RST;
    else fs <= fs_d;
  end

  // System side
  logic hold_mode;
  logic hw_mode;

  always_comb begin
    q_d = q;
    q_d.cs_s1 = cs_n_i;
    q_d.cs_s2 = q.cs_s1;
    q_d.sck_s1 = sclk_i;
    q_d.sck_s2 = q.sck_s1;
    q_d.pn_s1 = dl_i[3];
    q_d.pn_s2 = q.pn_s1;
    q_d.por_s1 = por_i;
    q_d.por_s2 = q.por_s1;
    q_d.od_s1 = rs.op_done;
    q_d.od_s2 = q.od_s1;
    q_d.od_prev = q.od_s2;
    q_d.ad_s1 = rs.addr_done;
    q_d.ad_s2 = q.ad_s1;
    q_d.ad_prev = q.ad_s2;
    q_d.qe = quad_enable_bit_i;
    q_d.hs = pause_or_reset_select_i;
    q_d.op_valid = 1'b0;
    q_d.addr_valid = 1'b0;
    q_d.sw_reset = 1'b0;
    hold_mode = !q.qe && !q.hs;
    hw_mode = !q.qe && q.hs;
    if (q.cs_s2) begin
      q_d.armed = 1'b1;
    end
    if (q.od_s2 && !q.od_prev) begin
      q_d.op_valid = 1'b1;
      q_d.opcode = rs.op;
      q_d.rst_en = (rs.op == sfb_pkg::OP_RST_EN);
      if (rs.op == sfb_pkg::OP_RST && q.rst_en) begin
        q_d.rst_busy = 1'b1;
        q_d.rcnt = '0;
        q_d.sw_reset = 1'b1;
      end
    end
    if (q.ad_s2 && !q.ad_prev) begin
      q_d.addr_valid = 1'b1;
      q_d.addr = rs.addr[sfb_pkg::ADDR_W-1:0];
      q_d.sector = rs.addr[sfb_pkg::ADDR_W-1:sfb_pkg::SEC_LSB];
      q_d.half_block = rs.addr[sfb_pkg::ADDR_W-1:sfb_pkg::HBLK_LSB];
      q_d.block = rs.addr[sfb_pkg::ADDR_W-1:sfb_pkg::BLK_LSB];
    end
    if (q.rst_busy) begin
      q_d.rcnt = q.rcnt + 16'h0001;
      if (q.rcnt == sfb_pkg::RCNT_W'(RST_CYCLES - 1)) begin
        q_d.rst_busy = 1'b0;
        q_d.armed = 1'b0;
        q_d.rst_en = 1'b0;
      end
    end
    q_d.hw_low = hw_mode && !q.pn_s2;
    if (q.hw_low || q.por_s2) begin
      q_d.armed = 1'b0;
      q_d.rst_en = 1'b0;
      q_d.rst_busy = 1'b0;
    end
    q_d.acc = q.armed && !q.por_s2 && !q.rst_busy && !q.hw_low;
    q_d.selected = !q.cs_s2 && q.armed;
    q_d.standby = q.cs_s2 && !write_busy_i;
    if (!hold_mode || q.cs_s2) begin
      q_d.paused = 1'b0;
    end else if (!q.sck_s2) begin
      q_d.paused = !q.pn_s2;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) q <= '0;
    else q <= q_d;
  end

  assign dl_o = fs.dq;
  assign dl_oe_n_o = fs.oe_n;
  assign opcode_o = q.opcode;
  assign op_valid_o = q.op_valid;
  assign addr_o = q.addr;
  assign addr_valid_o = q.addr_valid;
  assign sector_o = q.sector;
  assign half_block_o = q.half_block;
  assign block_o = q.block;
  assign selected_o = q.selected;
  assign standby_o = q.standby;
  assign paused_o = q.paused;
  assign reset_busy_o = q.rst_busy;
  assign sw_reset_o = q.sw_reset;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  property p_sector;
    addr_valid_o |-> (sector_o == addr_o[17:12]) && ({sector_o, 12'h000} <= addr_o);
  endproperty
  a_sector: assert property (p_sector) else $error("sector number mismatch");
  property p_half;
    addr_valid_o |-> half_block_o == sector_o[5:3];
  endproperty
  a_half: assert property (p_half) else $error("half block mismatch");
  property p_block;
    addr_valid_o |-> block_o == half_block_o[2:1];
  endproperty
  a_block: assert property (p_block) else $error("block mismatch");
  property p_por;
    q.por_s2 |=> !q.acc ##1 !q.acc;
  endproperty
  a_por: assert property (p_por) else $error("accepting during power-on reset");
  property p_rst_hold;
    sw_reset_o |=> reset_busy_o[*8];
  endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("recovery ended too early");
  property p_rst_cancel;
    op_valid_o && opcode_o != sfb_pkg::OP_RST_EN |-> !q.rst_en;
  endproperty
  a_rst_cancel: assert property (p_rst_cancel) else $error("reset enable not cancelled");
  property p_no_arm_low;
    !q.armed && !q.cs_s2 && !q.rst_busy |=> !q.armed;
  endproperty
  a_no_arm_low: assert property (p_no_arm_low) else $error("armed without select high");
  property p_standby;
    q.cs_s2 && !write_busy_i |=> standby_o;
  endproperty
  a_standby: assert property (p_standby) else $error("standby not entered");
  property p_pause_in;
    !q.qe && !q.hs && !q.cs_s2 && !q.sck_s2 && !q.pn_s2 |=> paused_o;
  endproperty
  a_pause_in: assert property (p_pause_in) else $error("pause not entered");
  property p_pause_drop;
    $rose(q.cs_s2) |=> !paused_o;
  endproperty
  a_pause_drop: assert property (p_pause_drop) else $error("pause kept after deselect");
endmodule

//--- verification/sfb_host_model.sv
`timescale 1ns/1ps
module sfb_host_model (
  output logic sclk_o,
  output logic cs_n_o,
  output logic [3:0] dl_o,
  output logic [3:0] dl_en_o,
  input wire logic [3:0] dl_i,
  input wire logic [3:0] dl_oe_n_i
);
  logic idle_hi;
  logic hold_lvl;
  logic [3:0] last_oe;
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b0;
    dl_o = 4'hf;
    dl_en_o = 4'h8;
    idle_hi = 1'b0;
    hold_lvl = 1'b1;
    last_oe = 4'hf;
  end
  // Set while the clock is low, held across the rising edge; reads on the rise
  task automatic bits(input logic [31:0] v, input int n, input int ln, input bit drv, output logic [31:0] rx);
    int i;
    int k;
    rx = '0;
    for (i = n / ln - 1; i >= 0; i--) begin
      sclk_o = 1'b0;
      for (k = 0; k < ln; k++) dl_o[k] = v[i * ln + k];
      dl_en_o = drv ? 4'((1 << ln) - 1) : 4'h0;
      if (ln < 4) begin
        dl_o[3] = hold_lvl;
        dl_en_o[3] = 1'b1;
      end
      #15;
      sclk_o = 1'b1;
      last_oe = dl_oe_n_i;
      rx = (rx << ln) | (ln == 1 ? 32'(dl_i[1]) : 32'(dl_i & 4'((1 << ln) - 1)));
      #15;
    end
  endtask
  task automatic set_pause(input logic lvl);
    hold_lvl = lvl;
    dl_o[3] = lvl;
    dl_en_o[3] = 1'b1;
  endtask
  task automatic set_sclk(input logic lvl);
    sclk_o = lvl;
  endtask
  task automatic open_frame();
    sclk_o = idle_hi;
    #3;
    cs_n_o = 1'b0;
    #30;
  endtask
  task automatic close_frame();
    #15;
    sclk_o = idle_hi;
    #60;
    cs_n_o = 1'b1;
    dl_en_o = 4'h8;
    dl_o[3] = hold_lvl;
    #60;
  endtask
  task automatic frame(input logic [7:0] op, input logic [23:0] a, input int aln, input int mcl, input int dcl,
                       input int oln, output logic [7:0] rx);
    logic [31:0] r;
    open_frame();
    bits(32'(op), 8, 1, 1'b1, r);
    if (aln > 0) bits(32'(a), 24, aln, 1'b1, r);
    if (mcl > 0) bits(32'h0, mcl * aln, aln, 1'b1, r);
    if (dcl > 0) bits(32'h0, dcl, 1, 1'b0, r);
    if (oln > 0) bits(32'h0, 8, oln, 1'b0, r);
    rx = r[7:0];
    close_frame();
  endtask
endmodule

//--- verification/test_serial_flash_bus_front_end.sv
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; $display("unexpected at %0t: got %0h want %0h", $time, g, e); end end
module test_serial_flash_bus_front_end;
  localparam int RSTC = 200;
  localparam logic [7:0] RD = 8'hc6;
  localparam logic [7:0] OPS [6] = '{8'h03, 8'h0b, 8'h3b, 8'hbb, 8'h6b, 8'heb};
  localparam logic [23:0] ADS [6] = '{24'h03ffff, 24'h008000, 24'h017abc, 24'h02f123, 24'h001000, 24'h030fff};
  localparam int AL [6] = '{1, 1, 1, 2, 1, 4};
  localparam int ML [6] = '{0, 0, 0, 4, 0, 2};
  localparam int DL [6] = '{0, 8, 8, 0, 8, 4};
  localparam int OL [6] = '{1, 1, 2, 2, 4, 4};
  localparam logic [3:0] OE [6] = '{4'hd, 4'hd, 4'hc, 4'hc, 4'h0, 4'h0};
  logic clk_i, rstn_i, por, qe, prs, wbusy, tog, sclk, cs_n;
  logic [3:0] h_dl, h_en, line, d_o, oe_n;
  logic [7:0] opcode, rx, rd;
  logic [17:0] addr;
  logic [5:0] sector;
  logic [2:0] half;
  logic [1:0] blk;
  logic op_valid, addr_valid, selected, standby, paused, rbusy, swr;
  logic [31:0] r;
  int fail_count, compares, ops, swrs, busy, d, avs;
  sfb_front_end #(.RST_CYCLES(RSTC)) sfb_front_end_i (.clk_i(clk_i), .rstn_i(rstn_i), .sclk_i(sclk), .cs_n_i(cs_n),
    .dl_i(line), .por_i(por), .quad_enable_bit_i(qe), .pause_or_reset_select_i(prs), .write_busy_i(wbusy),
    .rd_data_i(rd), .dl_o(d_o), .dl_oe_n_o(oe_n), .opcode_o(opcode), .op_valid_o(op_valid), .addr_o(addr),
    .addr_valid_o(addr_valid), .sector_o(sector), .half_block_o(half), .block_o(blk), .selected_o(selected),
    .standby_o(standby), .paused_o(paused), .reset_busy_o(rbusy), .sw_reset_o(swr));
  sfb_host_model sfb_host_model_i (.sclk_o(sclk), .cs_n_o(cs_n), .dl_o(h_dl), .dl_en_o(h_en), .dl_i(line),
    .dl_oe_n_i(oe_n));
  // Released lines 0 and 1 float and read as a moving pattern; lines 2 and 3 have pull-ups
  always_comb for (int k = 0; k < 4; k++) line[k] = !oe_n[k] ? d_o[k] : h_en[k] ? h_dl[k] : (k >= 2 ? 1'b1 : tog);
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    tog <= ~tog;
    if (op_valid === 1'b1) ops++;
    if (addr_valid === 1'b1) avs++;
    if (swr === 1'b1) swrs++;
    if (rbusy === 1'b1) busy++;
  end
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic opf(input logic [7:0] op, output int dd);
    int n;
    n = ops;
    sfb_host_model_i.frame(op, 24'h0, 0, 0, 0, 0, rx);
    tick(2);
    dd = ops - n;
  endtask
  task automatic t_powerup();
    sfb_host_model_i.bits(32'h03, 8, 1, 1'b1, r);
    tick(6);
    `CHK(ops, 0)
    `CHK(selected, 1'b0)
    sfb_host_model_i.close_frame();
    opf(8'h03, d);
    `CHK(d, 1)
  endtask
  task automatic t_standby();
    `CHK(standby, 1'b1)
    wbusy = 1'b1;
    tick(4);
    `CHK(standby, 1'b0)
    wbusy = 1'b0;
    sfb_host_model_i.open_frame();
    tick(4);
    `CHK(selected, 1'b1)
    `CHK(standby, 1'b0)
    sfb_host_model_i.close_frame();
    tick(4);
    `CHK(standby, 1'b1)
  endtask
  task automatic t_reads();
    int n;
    int na;
    for (int i = 0; i < 6; i++) begin
      qe = (OL[i] == 4);
      rd = RD ^ 8'(i * 37);
      sfb_host_model_i.idle_hi = (i == 1);
      tick(4);
      n = ops;
      na = avs;
      sfb_host_model_i.frame(OPS[i], ADS[i], AL[i], ML[i], DL[i], OL[i], rx);
      tick(2);
      `CHK(ops, n + 1)
      `CHK(opcode, OPS[i])
      `CHK(addr, ADS[i][17:0])
      `CHK(sector, 6'(ADS[i] / 24'h1000))
      `CHK(half, 3'(ADS[i] / 24'h8000))
      `CHK(blk, 2'(ADS[i] / 24'h10000))
      `CHK(avs, na + 1)
      `CHK(rx, rd)
      `CHK(sfb_host_model_i.last_oe, OE[i])
      `CHK(oe_n, 4'hf)
    end
    sfb_host_model_i.idle_hi = 1'b0;
    qe = 1'b0;
    tick(4);
    opf(8'h6b, d);
    `CHK(d, 0)
  endtask
  task automatic t_pause();
    sfb_host_model_i.open_frame();
    sfb_host_model_i.bits(32'h03, 8, 1, 1'b1, r);
    sfb_host_model_i.bits(32'h012, 12, 1, 1'b1, r);
    sfb_host_model_i.set_pause(1'b0);
    tick(6);
    `CHK(paused, 1'b0)
    sfb_host_model_i.set_sclk(1'b0);
    tick(6);
    `CHK(paused, 1'b1)
    `CHK(oe_n, 4'hf)
    sfb_host_model_i.bits(32'h3, 2, 1, 1'b1, r);
    sfb_host_model_i.set_sclk(1'b0);
    sfb_host_model_i.set_pause(1'b1);
    tick(6);
    `CHK(paused, 1'b0)
    sfb_host_model_i.bits(32'h345, 12, 1, 1'b1, r);
    sfb_host_model_i.bits(32'h0, 8, 1, 1'b0, r);
    sfb_host_model_i.close_frame();
    `CHK(addr, 18'h12345)
    `CHK(r[7:0], rd)
    sfb_host_model_i.open_frame();
    sfb_host_model_i.bits(32'h03, 8, 1, 1'b1, r);
    sfb_host_model_i.set_sclk(1'b0);
    sfb_host_model_i.set_pause(1'b0);
    tick(6);
    `CHK(paused, 1'b1)
    sfb_host_model_i.close_frame();
    `CHK(paused, 1'b0)
    sfb_host_model_i.set_pause(1'b1);
    tick(6);
    `CHK(paused, 1'b0)
  endtask
  task automatic t_resets();
    prs = 1'b1;
    sfb_host_model_i.set_pause(1'b0);
    tick(4);
    opf(8'h03, d);
    `CHK(d, 0)
    sfb_host_model_i.set_pause(1'b1);
    prs = 1'b0;
    tick(4);
    opf(8'h03, d);
    `CHK(d, 1)
    por = 1'b1;
    tick(4);
    opf(8'h03, d);
    `CHK(d, 0)
    por = 1'b0;
    tick(4);
    opf(8'h03, d);
    `CHK(d, 1)
  endtask
  task automatic t_swreset();
    opf(8'h99, d);
    opf(8'h66, d);
    opf(8'h03, d);
    opf(8'h99, d);
    `CHK(swrs, 0)
    opf(8'h66, d);
    busy = 0;
    opf(8'h99, d);
    `CHK(swrs, 1)
    `CHK(rbusy, 1'b1)
    opf(8'h03, d);
    `CHK(d, 0)
    for (int i = 0; i < 400 && rbusy === 1'b1; i++) tick(1);
    `CHK(busy, RSTC)
    opf(8'h03, d);
    `CHK(d, 1)
  endtask
  initial begin
    #400000;
    fail_count++;
    conclude();
  end
  initial begin
    {clk_i, rstn_i, por, qe, prs, wbusy, tog} = 7'h0;
    rd = RD;
    repeat (4) @(posedge clk_i);
    #1;
    rstn_i = 1'b1;
    tick(6);
    `CHK(rbusy, 1'b0)
    t_powerup();
    t_standby();
    t_reads();
    t_pause();
    t_resets();
    t_swreset();
    conclude();
  end
endmodule
